// *** hdl/cir_image_ctrl_regs.sv ***
/*
  Camera image control register bank: compression, buffer share, quality
  ceiling, user sets, shutter and software trigger, on an APB slave port.
  Assumes a synchronous APB master on clk; the exposure engine, trigger
  logic and auto-exposure controller sit outside and use the ports below.
*/
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module cir_image_ctrl_regs
  import cir_pkg::*;
#(
  parameter bit NEW_SHARE_DEFAULT = 1'b0,
  parameter int PUSH_CYCLES = ONE_PUSH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Compression
  output logic realtime_transport_enable,
  output logic compression_enable,
  output logic auto_quality_mode,
  output logic [Q_W-1:0] quality_code,
  output logic [SH_W-1:0] buffer_share_code,
  output logic [SH_W-1:0] quality_ceiling,
  input wire logic [Q_W-1:0] auto_quality_in,
  // Shutter
  input wire logic extended_shutter_mode,
  input wire logic ae_enable,
  input wire logic [VAL_W-1:0] ae_shutter_value,
  output logic [HI_W+VAL_W-1:0] shutter_raw,
  output logic one_push_active,
  // Trigger
  input wire logic [MODE_W-1:0] trigger_mode,
  input wire logic hw_trigger,
  input wire logic capture_done,
  output logic sw_trigger_pulse,
  output logic trigger_busy
);
  cir_apb_s apb;
  cir_settings_s cfg_reg;
  cir_settings_s cfg_next;
  cir_settings_s restore;
  cir_shut_e sh_state;
  logic [HI_W-1:0] sh_hi_reg;
  logic [HI_W-1:0] sh_hi_next;
  logic init_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [DW-1:0] prdata_reg;
  logic rtp_out_reg;
  logic cmp_out_reg;
  logic qa_out_reg;
  logic [Q_W-1:0] q_out_reg;
  logic [Q_W-1:0] q_next;
  logic [SH_W-1:0] share_out_reg;
  logic [SH_W-1:0] ceil_out_reg;
  logic [HI_W+VAL_W-1:0] shut_out_reg;
  logic [HI_W+VAL_W-1:0] shut_next;
  logic trig_reg;
  logic trig_next;
  logic sw_pulse_reg;
  logic [CH_W-1:0] last_ch;
  logic push_busy;
  logic push_done;

  // Bus decode
  assign apb = '{addr: paddr, wdata: pwdata, write: pwrite, sel: psel, enable: penable};
  logic hit_trig, hit_shut, hit_ctrl, hit_share, hit_ceil, hit_abs, hit_mem;
  logic mapped, acc_first, acc_done, wr, wr_ctrl, wr_shut, wr_abs, wr_mem;
  assign hit_trig = (apb.addr == OFS_TRIG);
  assign hit_shut = (apb.addr == OFS_SHUT);
  assign hit_ctrl = (apb.addr == OFS_CTRL);
  assign hit_share = (apb.addr == OFS_SHARE);
  assign hit_ceil = (apb.addr == OFS_CEIL);
  assign hit_abs = (apb.addr == OFS_ABS);
  assign hit_mem = (apb.addr == OFS_MEM);
  assign mapped = hit_trig | hit_shut | hit_ctrl | hit_share | hit_ceil | hit_abs | hit_mem;
  // One wait state keeps read data and pready straight from flip-flops
  assign acc_first = apb.sel & apb.enable & ~pready_reg;
  assign acc_done = apb.sel & apb.enable & pready_reg;
  assign wr = acc_done & apb.write & mapped;
  assign wr_ctrl = wr & hit_ctrl;
  assign wr_shut = wr & hit_shut;
  assign wr_abs = wr & hit_abs;
  assign wr_mem = wr & hit_mem;

  // User sets and reinitialisation
  logic mem_save, mem_load, load_now;
  logic [CH_W-1:0] mem_ch;
  assign mem_ch = apb.wdata[MEM_CH_LSB +: CH_W];
  assign mem_save = wr_mem & apb.wdata[MEM_SAVE];
  assign mem_load = wr_mem & apb.wdata[MEM_LOAD];
  assign load_now = init_reg | mem_load;

  cir_user_sets #(
    .NSETS(NUM_SETS)
  ) u_sets (
    .clk(clk),
    .srst(srst),
    .save(mem_save),
    .save_ch(mem_ch),
    .cur(cfg_reg),
    .last_ch(last_ch),
    .restore(restore)
  );

  // Shutter state
  assign sh_state = cfg_reg.sh_auto ? SH_AUTO : (cfg_reg.sh_abs ? SH_MAN_ABS : SH_MANUAL);

  logic push_start;
  assign push_start = wr_shut & apb.wdata[B_OPUSH] & cfg_reg.sh_on & ~cfg_reg.sh_auto;

  cir_busy_timer #(
    .CYCLES(PUSH_CYCLES)
  ) u_push (
    .clk(clk),
    .srst(srst),
    .start(push_start),
    .busy(push_busy),
    .done(push_done)
  );

  // Field write gating
  logic ctrl_open, q_open, sh_open, val_open, abs_open;
  assign ctrl_open = cfg_reg.cmp_on;
  assign q_open = cfg_reg.cmp_on & ~cfg_reg.q_auto;
  assign sh_open = cfg_reg.sh_on;
  assign val_open = sh_open & (sh_state == SH_MANUAL);
  assign abs_open = sh_open & (sh_state == SH_MAN_ABS);

  always_comb begin
    cfg_next = cfg_reg;
    if (load_now) begin
      cfg_next = restore;
    end else begin
      if (wr_ctrl) begin
        cfg_next.cmp_on = apb.wdata[B_ONOFF];
        if (ctrl_open) begin
          cfg_next.rtp = apb.wdata[B_RTP];
          cfg_next.q_auto = apb.wdata[B_AM];
        end
        if (q_open) cfg_next.quality = apb.wdata[Q_W-1:0];
      end
      if (wr & hit_share) cfg_next.share = apb.wdata[SH_W-1:0];
      if (wr & hit_ceil) cfg_next.ceil = apb.wdata[SH_W-1:0];
      if (wr_shut) begin
        cfg_next.sh_on = apb.wdata[B_ONOFF];
        if (sh_open) begin
          cfg_next.sh_abs = apb.wdata[B_ABS];
          cfg_next.sh_auto = apb.wdata[B_AM];
        end
        if (val_open) cfg_next.sh_value = apb.wdata[VAL_W-1:0];
      end
      if (wr_abs && abs_open) cfg_next.abs_time = apb.wdata;
      // One push result lands in the value field of a manual shutter
      if (push_done && sh_state == SH_MANUAL) cfg_next.sh_value = ae_shutter_value;
    end
  end

  // Upper shutter bits exist only in the extended mode
  always_comb begin
    sh_hi_next = sh_hi_reg;
    if (!extended_shutter_mode) sh_hi_next = '0;
    else if (wr_shut && val_open) sh_hi_next = apb.wdata[HI_LSB +: HI_W];
  end

  // Applied values
  logic [VAL_W-1:0] abs_raw;
  logic [Q_W-1:0] ceil_wide;
  // Conversion is one raw step per time unit; only the low 12 bits of the time are kept
  assign abs_raw = cfg_reg.abs_time[VAL_W-1:0];
  assign ceil_wide = Q_W'(cfg_reg.ceil);

  always_comb begin
    if (cfg_reg.q_auto) begin
      q_next = (auto_quality_in > ceil_wide) ? ceil_wide : auto_quality_in;
    end else begin
      q_next = (cfg_reg.quality == '0) ? QUAL_ZERO : cfg_reg.quality;
    end
  end

  always_comb begin
    case (sh_state)
      SH_MANUAL: shut_next = {sh_hi_reg, cfg_reg.sh_value};
      SH_MAN_ABS: shut_next = {sh_hi_reg, abs_raw};
      SH_AUTO: shut_next = ae_enable ? {sh_hi_reg, ae_shutter_value} : shut_out_reg;
      default: shut_next = shut_out_reg;
    endcase
  end

  // Trigger: a new trigger in the clearing cycle wins
  logic trig_set, trig_clr;
  assign trig_set = (wr & hit_trig & apb.wdata[B_TRIG]) | hw_trigger;
  assign trig_clr = (wr & hit_trig & ~apb.wdata[B_TRIG])
    | (capture_done & (trigger_mode != TRIG_MODE_KEEP));
  assign trig_next = trig_set | (trig_reg & ~trig_clr);

  // Read back
  logic [DW-1:0] rd_trig, rd_shut, rd_ctrl, rd_share, rd_ceil, rd_abs, rd_mem, rd_word;
  logic [VAL_W-1:0] val_view;
  assign val_view = (sh_state == SH_MAN_ABS) ? abs_raw : cfg_reg.sh_value;
  assign rd_trig = DW'(trig_reg) << B_TRIG;
  assign rd_shut = (DW'(1) << B_PRES) | (DW'(cfg_reg.sh_abs) << B_ABS)
    | (DW'(push_busy) << B_OPUSH) | (DW'(cfg_reg.sh_on) << B_ONOFF)
    | (DW'(cfg_reg.sh_auto) << B_AM) | (DW'(sh_hi_reg) << HI_LSB) | DW'(val_view);
  assign rd_ctrl = (DW'(1) << B_PRES) | (DW'(cfg_reg.rtp) << B_RTP)
    | (DW'(cfg_reg.cmp_on) << B_ONOFF) | (DW'(cfg_reg.q_auto) << B_AM)
    | DW'(cfg_reg.quality);
  assign rd_share = (DW'(1) << B_PRES) | DW'(cfg_reg.share);
  assign rd_ceil = (DW'(1) << B_PRES) | DW'(cfg_reg.ceil);
  // Outside manual-absolute the register shows the applied time
  assign rd_abs = (sh_state == SH_MAN_ABS) ? cfg_reg.abs_time
    : DW'(shut_out_reg[VAL_W-1:0]);
  assign rd_mem = DW'(last_ch) << MEM_LAST_LSB;
  assign rd_word = hit_trig ? rd_trig : hit_shut ? rd_shut : hit_ctrl ? rd_ctrl
    : hit_share ? rd_share : hit_ceil ? rd_ceil : hit_abs ? rd_abs
    : hit_mem ? rd_mem : RD_UNMAPPED;

  // Bus registers
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_reg <= 1'h0;
      pslverr_reg <= 1'h0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= acc_first;
      pslverr_reg <= acc_first & ~mapped;
      if (acc_first && !apb.write) prdata_reg <= rd_word;
    end
  end

  // Settings registers; the first cycle after reset loads the factory set
  always_ff @(posedge clk) begin
    if (srst) begin
      init_reg <= 1'h1;
      cfg_reg <= FACTORY;
      sh_hi_reg <= '0;
      trig_reg <= 1'h0;
      sw_pulse_reg <= 1'h0;
    end else begin
      init_reg <= 1'h0;
      cfg_reg <= cfg_next;
      sh_hi_reg <= sh_hi_next;
      trig_reg <= trig_next;
      sw_pulse_reg <= wr & hit_trig & apb.wdata[B_TRIG];
    end
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rtp_out_reg <= 1'h0;
      cmp_out_reg <= 1'h0;
      qa_out_reg <= 1'h0;
      q_out_reg <= QUAL_ZERO;
      share_out_reg <= NEW_SHARE_DEFAULT ? SHARE_ZERO_NEW : SHARE_ZERO_OLD;
      ceil_out_reg <= CEIL_RST;
      shut_out_reg <= '0;
    end else begin
      rtp_out_reg <= cfg_reg.rtp;
      cmp_out_reg <= cfg_reg.cmp_on;
      qa_out_reg <= cfg_reg.q_auto;
      q_out_reg <= q_next;
      share_out_reg <= (cfg_reg.share != '0) ? cfg_reg.share
        : (NEW_SHARE_DEFAULT ? SHARE_ZERO_NEW : SHARE_ZERO_OLD);
      ceil_out_reg <= cfg_reg.ceil;
      shut_out_reg <= shut_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign realtime_transport_enable = rtp_out_reg;
  assign compression_enable = cmp_out_reg;
  assign auto_quality_mode = qa_out_reg;
  assign quality_code = q_out_reg;
  assign buffer_share_code = share_out_reg;
  assign quality_ceiling = ceil_out_reg;
  assign shutter_raw = shut_out_reg;
  assign one_push_active = push_busy;
  assign sw_trigger_pulse = sw_pulse_reg;
  assign trigger_busy = trig_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_PRESENT: assert property (
    acc_first && !apb.write && hit_ctrl |=> prdata[B_PRES])
    else $error("present bit not read as one");
  AST_SHARE_ZERO: assert property (
    cfg_reg.share == '0 |=> share_out_reg == (NEW_SHARE_DEFAULT ? SHARE_ZERO_NEW : SHARE_ZERO_OLD))
    else $error("zero share not mapped to default");
  AST_RTP_FOLLOW: assert property (
    wr_ctrl && ctrl_open && !load_now |=> ##1 rtp_out_reg == $past(apb.wdata[B_RTP], 2))
    else $error("transport enable did not follow write");
  AST_OFF_FREEZE: assert property (
    wr_ctrl && !ctrl_open && !load_now |=> $stable(cfg_reg.q_auto) && $stable(cfg_reg.rtp))
    else $error("field changed while compression off");
  AST_QUAL_ZERO: assert property (
    !cfg_reg.q_auto && cfg_reg.quality == '0 |=> quality_code == QUAL_ZERO)
    else $error("zero quality not applied as sixty");
  AST_AUTO_IGNORE: assert property (
    wr_ctrl && cfg_reg.q_auto && !load_now |=> $stable(cfg_reg.quality))
    else $error("quality written in auto mode");
  AST_CEIL_LIMIT: assert property (
    cfg_reg.q_auto |=> quality_code <= Q_W'($past(cfg_reg.ceil)))
    else $error("auto quality above ceiling");
  AST_FACTORY_SAVE: assert property (
    mem_save && mem_ch == '0 |=> last_ch == '0)
    else $error("save to factory set not honoured");
  AST_ABS_SOURCE: assert property (
    sh_state == SH_MAN_ABS |=> shutter_raw[VAL_W-1:0] == $past(abs_raw))
    else $error("shutter not taken from absolute time");
  AST_PUSH_END: assert property (
    push_start && !push_busy |=> one_push_active ##[1:1000] !one_push_active)
    else $error("one push did not self clear");
  AST_TRIG_SET: assert property (
    trig_set |=> trigger_busy)
    else $error("trigger not reported busy");
  AST_TRIG_MODE3: assert property (
    trig_reg && trigger_mode == TRIG_MODE_KEEP && !(wr && hit_trig) |=> trigger_busy)
    else $error("trigger cleared itself in mode three");
  AST_PREADY: assert property (
    acc_first |=> pready ##1 !pready)
    else $error("bus answer not one wait state");

  COV_CTRL_WR: cover property (wr_ctrl ##2 realtime_transport_enable);
  COV_PUSH: cover property (push_start ##1 one_push_active);
  COV_TRIG: cover property (trig_set ##1 trigger_busy ##[1:20] !trigger_busy);
  COV_RESTORE: cover property (mem_load);
endmodule
`default_nettype wire

// *** hdl/cir_pkg.sv ***
/*
  Constants and types shared by the camera image control register bank.
  Assumes a 200 MHz clock and a 32-bit APB register port.
*/
package cir_pkg;
  localparam int AW = 16;
  localparam int DW = 32;
  // Byte addresses of the registers
  localparam logic [AW-1:0] OFS_TRIG = 16'h062C;
  localparam logic [AW-1:0] OFS_SHUT = 16'h081C;
  localparam logic [AW-1:0] OFS_CTRL = 16'h1E80;
  localparam logic [AW-1:0] OFS_SHARE = 16'h1E84;
  localparam logic [AW-1:0] OFS_CEIL = 16'h1E8C;
  localparam logic [AW-1:0] OFS_ABS = 16'h1F00;
  localparam logic [AW-1:0] OFS_MEM = 16'h1F04;
  // Bit n counted from the MSB sits at vector index 31-n
  localparam int B_PRES = 31;
  localparam int B_TRIG = 31;
  localparam int B_RTP = 30;
  localparam int B_ABS = 30;
  localparam int B_OPUSH = 26;
  localparam int B_ONOFF = 25;
  localparam int B_AM = 24;
  localparam int VAL_W = 12;
  localparam int HI_W = 4;
  localparam int HI_LSB = 12;
  localparam int Q_W = 8;
  localparam int SH_W = 7;
  localparam int MODE_W = 4;
  localparam int CH_W = 2;
  localparam int MEM_CH_LSB = 0;
  localparam int MEM_LAST_LSB = 4;
  localparam int MEM_SAVE = 8;
  localparam int MEM_LOAD = 9;
  localparam int NUM_SETS = 3;
  localparam logic [SH_W-1:0] SHARE_ZERO_OLD = 7'h66;
  localparam logic [SH_W-1:0] SHARE_ZERO_NEW = 7'h72;
  localparam logic [SH_W-1:0] CEIL_RST = 7'h50;
  localparam logic [Q_W-1:0] QUAL_ZERO = 8'h3C;
  localparam logic [MODE_W-1:0] TRIG_MODE_KEEP = 4'h3;
  localparam logic [DW-1:0] RD_UNMAPPED = 32'h0000_0000;
  localparam int CLK_NS = 5;
  localparam int ONE_PUSH_NS = 1000;
  localparam int ONE_PUSH_CYC = (ONE_PUSH_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic write;
    logic sel;
    logic enable;
  } cir_apb_s;

  typedef struct packed {
    logic rtp;
    logic cmp_on;
    logic q_auto;
    logic [Q_W-1:0] quality;
    logic [SH_W-1:0] share;
    logic [SH_W-1:0] ceil;
    logic sh_abs;
    logic sh_on;
    logic sh_auto;
    logic [VAL_W-1:0] sh_value;
    logic [DW-1:0] abs_time;
  } cir_settings_s;

  localparam cir_settings_s FACTORY = '{rtp: 1'h0, cmp_on: 1'h1, q_auto: 1'h0,
    quality: 8'h00, share: 7'h00, ceil: CEIL_RST, sh_abs: 1'h0, sh_on: 1'h1,
    sh_auto: 1'h0, sh_value: 12'h100, abs_time: 32'h0000_0100};

  typedef enum logic [1:0] {SH_MANUAL, SH_MAN_ABS, SH_AUTO} cir_shut_e;
endpackage

// *** hdl/cir_busy_timer.sv ***
/*
  Busy interval of fixed length, started by a one-cycle pulse.
  A start while busy is ignored.
*/
`timescale 1ns/100ps
`default_nettype none
module cir_busy_timer #(
  parameter int CYCLES = 200
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic busy_reg;

  // Busy is registered so that it may drive a top-level output directly
  assign busy = busy_reg;
  assign done = (cnt_reg == ONE);
  assign cnt_next = start && !busy ? LOAD : (busy ? cnt_reg - ONE : cnt_reg);

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
      busy_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= (cnt_next != '0);
    end
  end
endmodule
`default_nettype wire

// *** hdl/cir_user_sets.sv ***
/*
  Saved user sets: set 0 is the fixed factory set, the rest are writable.
  The restore output always shows the set saved last.
*/
`timescale 1ns/100ps
`default_nettype none
module cir_user_sets
  import cir_pkg::*;
#(
  parameter int NSETS = NUM_SETS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Save request
  input wire logic save,
  input wire logic [CH_W-1:0] save_ch,
  input wire cir_settings_s cur,
  // Restore side
  output logic [CH_W-1:0] last_ch,
  output cir_settings_s restore
);
  localparam logic [CH_W-1:0] CH_FACT = '0;
  cir_settings_s sets_reg [NSETS];
  logic [CH_W-1:0] last_reg;
  logic ch_ok;

  assign ch_ok = (int'(save_ch) < NSETS);
  assign last_ch = last_reg;
  assign restore = (last_reg == CH_FACT) ? FACTORY : sets_reg[last_reg];

  always_ff @(posedge clk) begin
    if (srst) begin
      last_reg <= CH_FACT;
    end else if (save && ch_ok) begin
      last_reg <= save_ch;
    end
  end

  // Entry 0 never changes, so the factory set can always be restored
  always_ff @(posedge clk) begin
    sets_reg[0] <= FACTORY;
    for (int i = 1; i < NSETS; i++) begin
      if (srst) sets_reg[i] <= FACTORY;
      else if (save && int'(save_ch) == i) sets_reg[i] <= cur;
    end
  end
endmodule
`default_nettype wire

// *** dv/tb_cir_image_ctrl_regs.sv ***
/*
  Self-checking bench for the camera image control register bank.
  Assumes the bank's APB slave port, one 200 MHz clock and no far-side model.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_cir_image_ctrl_regs
  import cir_pkg::*;
;
  logic clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata;
  logic rte, cen, aqm, opa, swp, tbusy, ext, aee, hwt, capd;
  logic [Q_W-1:0] qc, aqi, q8;
  logic [SH_W-1:0] bsc, qcl, c;
  logic [VAL_W-1:0] aev;
  logic [HI_W+VAL_W-1:0] sraw;
  logic [MODE_W-1:0] tmode;
  logic [32:0] exp_q[$];
  logic [31:0] seed;
  logic [7:0] qv[3];
  int err_count, total_checks, cnt;

  cir_image_ctrl_regs #(.PUSH_CYCLES(5)) dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .realtime_transport_enable(rte),
    .compression_enable(cen), .auto_quality_mode(aqm), .quality_code(qc),
    .buffer_share_code(bsc), .quality_ceiling(qcl), .auto_quality_in(aqi),
    .extended_shutter_mode(ext), .ae_enable(aee), .ae_shutter_value(aev),
    .shutter_raw(sraw), .one_push_active(opa), .trigger_mode(tmode),
    .hw_trigger(hwt), .capture_done(capd), .sw_trigger_pulse(swp), .trigger_busy(tbusy));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(input logic [32:0] a, input logic [32:0] e);
    total_checks++;
    if (a !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, a, e);
    end
  endtask

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    cmp({1'b0, a}, {1'b0, e});
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Read results are judged here, in the order the reads were issued
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      cmp({pslverr, prdata}, exp_q.pop_front());
  end

  // Request held until pready is seen high; a stuck slave ends the run
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    bit ok;
    ok = 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk);
      ok = (pready === 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok) begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge clk);
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
    @(posedge clk);
  endtask

  task automatic count_push;
    cnt = 0;
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      if (opa === 1'b1) cnt++;
    end
  endtask

  task automatic done_pulse;
    capd <= 1'b1;
    @(posedge clk);
    capd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    {psel, penable, pwrite, ext, aee, hwt, capd} = '0;
    paddr = '0;
    pwdata = '0;
    tmode = '0;
    srst = 1'b1;
    seed = 32'h0001_4473;
    aqi = seed[7:0];
    aev = seed[19:8];
    qv = '{8'h01, 8'h64, 8'h00};
    err_count = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(qc), 32'h0000_003C);
    chk(32'(bsc), 32'h0000_0066);
    chk(32'(qcl), 32'h0000_0050);
    chk(32'(sraw), 32'h0000_0100);
    rd(OFS_CTRL, 33'h0_8200_0000);
    rd(OFS_CEIL, 33'h0_8000_0050);
    rd(16'h0000, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      c = (i == 0) ? 7'h00 : seed[6:0];
      wr(OFS_SHARE, {25'h0, c});
      chk(32'(bsc), 32'((c == 7'h00) ? 7'h66 : c));
      rd(OFS_SHARE, {2'b01, 24'h0, c});
    end
    foreach (qv[i]) begin
      wr(OFS_CTRL, 32'h4200_0000 | 32'(qv[i]));
      chk(32'(qc), 32'((qv[i] == 8'h00) ? 8'h3C : qv[i]));
    end
    chk(32'(rte), 32'h1);
    rd(OFS_CTRL, 33'h0_C200_0000);
    // Compression off: the quality and transport fields must be frozen
    wr(OFS_CTRL, 32'h4000_0000);
    wr(OFS_CTRL, 32'h0000_0055);
    chk({30'h0, cen, rte}, 32'h1);
    chk(32'(qc), 32'h0000_003C);
    rd(OFS_CTRL, 33'h0_C000_0000);
    wr(OFS_CTRL, 32'h0200_0030);
    // Transport bit was written while off, so it keeps its old value
    chk({30'h0, cen, rte}, 32'h3);
    wr(OFS_CEIL, 32'h0000_0040);
    chk(32'(qcl), 32'h0000_0040);
    wr(OFS_CTRL, 32'h0300_0030);
    wr(OFS_CTRL, 32'h0300_0010);
    chk(32'(aqm), 32'h1);
    rd(OFS_CTRL, 33'h0_8300_0030);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      aqi <= seed[7:0];
      q8 = (seed[7:0] < 8'h40) ? seed[7:0] : 8'h40;
      repeat (3) @(posedge clk);
      chk(32'(qc), 32'(q8));
    end
    wr(OFS_CTRL, 32'h0200_0030);
    chk(32'(aqm), 32'h0);
    // Upper shutter bits count only in extended mode
    wr(OFS_SHUT, 32'h0200_5ABC);
    chk(32'(sraw), 32'h0000_0ABC);
    ext <= 1'b1;
    wr(OFS_SHUT, 32'h0200_5ABC);
    chk(32'(sraw), 32'h0000_5ABC);
    wr(OFS_SHUT, 32'h4200_5ABC);
    wr(OFS_ABS, 32'h0000_0123);
    wr(OFS_SHUT, 32'h4200_5777);
    chk(32'(sraw[11:0]), 32'h0000_0123);
    wr(OFS_SHUT, 32'h0200_5ABC);
    wr(OFS_SHUT, 32'h0200_5ABC);
    wr(OFS_ABS, 32'h0000_0999);
    chk(32'(sraw[11:0]), 32'h0000_0ABC);
    rd(OFS_ABS, 33'h0_0000_0ABC);
    seed = lfsr(seed);
    aev <= seed[11:0];
    apb(1'b1, OFS_SHUT, 32'h0600_5ABC);
    count_push();
    chk(32'(cnt), 32'h5);
    chk(32'(sraw[11:0]), 32'(aev));
    aee <= 1'b1;
    wr(OFS_SHUT, 32'h0300_5ABC);
    seed = lfsr(seed);
    aev <= seed[11:0];
    apb(1'b1, OFS_SHUT, 32'h0700_5111);
    count_push();
    chk(32'(cnt), 32'h0);
    chk(32'(sraw[11:0]), 32'(aev));
    rd(OFS_SHUT, 33'h0_8300_5ABC);
    // Trigger in a self-clearing mode and in the mode that keeps busy
    for (int m = 0; m < 2; m++) begin
      tmode <= (m == 1) ? TRIG_MODE_KEEP : 4'h0;
      apb(1'b1, OFS_TRIG, 32'h8000_0000);
      @(posedge clk);
      chk({30'h0, swp, tbusy}, 32'h3);
      @(posedge clk);
      chk(32'(swp), 32'h0);
      rd(OFS_TRIG, 33'h0_8000_0000);
      done_pulse();
      chk(32'(tbusy), 32'(m));
      wr(OFS_TRIG, 32'h0000_0000);
      rd(OFS_TRIG, 33'h0_0000_0000);
    end
    tmode <= 4'h0;
    hwt <= 1'b1;
    @(posedge clk);
    hwt <= 1'b0;
    repeat (2) @(posedge clk);
    rd(OFS_TRIG, 33'h0_8000_0000);
    done_pulse();
    rd(OFS_TRIG, 33'h0_0000_0000);
    // Save to set one, disturb, restore; then saving to set zero means factory
    wr(OFS_MEM, 32'h0000_0101);
    wr(OFS_SHARE, 32'h0000_0011);
    wr(OFS_CTRL, 32'h0200_0022);
    wr(OFS_MEM, 32'h0000_0200);
    repeat (3) @(posedge clk);
    chk(32'(bsc), 32'((c == 7'h00) ? 7'h66 : c));
    chk(32'(qc), 32'h0000_0030);
    wr(OFS_MEM, 32'h0000_0100);
    wr(OFS_MEM, 32'h0000_0200);
    repeat (3) @(posedge clk);
    chk({17'h0, bsc, qc}, {17'h0, 7'h66, 8'h3C});
    chk(32'(qcl), 32'h0000_0050);
    if (exp_q.size() != 0) err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
